// ==== vlan_regs_pkg.sv ====
package vlan_regs_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // register byte addresses
    localparam logic [15:0] ENTRY0_ADDR   = 16'h0400;
    localparam logic [15:0] UNTAG_ADDR    = 16'h0404;
    localparam logic [15:0] FORWARD_ADDR  = 16'h0408;
    localparam logic [15:0] SELECTOR_ADDR = 16'h040c;
    localparam logic [15:0] CONTROL_ADDR  = 16'h040e;

    localparam int unsigned NUM_WORDS  = 4;
    localparam int unsigned NUM_ENTRY_WORDS = 3;
    localparam int unsigned WORD_BYTES = 4;
    localparam int unsigned SEL_BYTES  = 2;

    localparam logic [15:0] REG_BASE [NUM_WORDS] = '{
        ENTRY0_ADDR, UNTAG_ADDR, FORWARD_ADDR, SELECTOR_ADDR
    };
    localparam int unsigned REG_BYTES [NUM_WORDS] = '{
        WORD_BYTES, WORD_BYTES, WORD_BYTES, SEL_BYTES
    };

    ////////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int unsigned VALID_BIT  = 31;
    localparam int unsigned OVRD_BIT   = 27;
    localparam int unsigned PRIO_LSB   = 24;
    localparam int unsigned PRIO_W     = 3;
    localparam int unsigned STI_LSB    = 12;
    localparam int unsigned STI_W      = 3;
    localparam int unsigned FILT_LSB   = 0;
    localparam int unsigned FILT_W     = 7;
    localparam int unsigned PORT_W     = 7;
    localparam int unsigned VID_W      = 12;
    localparam int unsigned START_BIT  = 7;
    localparam int unsigned ACTION_LSB = 0;

    // writable bits; everything else reads zero
    localparam logic [31:0] REG_MASK [NUM_WORDS] = '{
        32'h8f00_707f, 32'h0000_007f, 32'h0000_007f, 32'h0000_0fff
    };
    localparam logic [7:0]  CONTROL_MASK = 8'h83;

    ////////////////////////////////////////////////////////////////////////////////
    // reset values and counts
    localparam logic [31:0] WORD_RST      = 32'h0000_0000;
    localparam logic [7:0]  BYTE_RST      = 8'h00;
    localparam int unsigned TABLE_DEPTH   = 4096;
    localparam logic [11:0] TABLE_LAST    = 12'hfff;
    localparam logic [11:0] INDEX_RST     = 12'h000;

    ////////////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [1:0] {
        ACT_NOP   = 2'b00,
        ACT_WRITE = 2'b01,
        ACT_READ  = 2'b10,
        ACT_CLEAR = 2'b11
    } action_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_READ  = 2'b01,
        ST_CLEAR = 2'b11
    } fsm_t;

    typedef struct packed {
        logic              valid;
        logic              forward_override;
        logic [PRIO_W-1:0] priority_level;
        logic [STI_W-1:0]  spanning_tree_instance;
        logic [FILT_W-1:0] filter_identifier;
        logic [PORT_W-1:0] untag_mask;
        logic [PORT_W-1:0] forward_mask;
    } vlan_entry_t;

    localparam int unsigned ENTRY_W = $bits(vlan_entry_t);
    localparam vlan_entry_t ENTRY_RST = '0;

    typedef struct packed {
        vlan_entry_t       entry;
        logic              ports_from_entry;
        logic [PORT_W-1:0] egress_ports;
    } lookup_result_t;

endpackage

// ==== vlan_table_ram.sv ====
`timescale 1ns/1ps

module vlan_table_ram (
    input  wire logic                            clk_in,
    input  wire logic                            sys_rst_in,
    input  wire logic                            a_en_in,
    input  wire logic                            a_we_in,
    input  wire logic [vlan_regs_pkg::VID_W-1:0] a_addr_in,
    input  wire vlan_regs_pkg::vlan_entry_t      a_wdata_in,
    output vlan_regs_pkg::vlan_entry_t           a_rdata_out,
    input  wire logic                            b_en_in,
    input  wire logic [vlan_regs_pkg::VID_W-1:0] b_addr_in,
    output vlan_regs_pkg::vlan_entry_t           b_rdata_out
);

    // contents are not reset; software runs a clear-all action to zero them
    logic [vlan_regs_pkg::ENTRY_W-1:0] mem [vlan_regs_pkg::TABLE_DEPTH];

    always_ff @(posedge clk_in) begin
        if (a_en_in && a_we_in) begin
            mem[a_addr_in] <= a_wdata_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            a_rdata_out <= vlan_regs_pkg::ENTRY_RST;
        end else if (a_en_in && !a_we_in) begin
            a_rdata_out <= mem[a_addr_in];
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            b_rdata_out <= vlan_regs_pkg::ENTRY_RST;
        end else if (b_en_in) begin
            b_rdata_out <= mem[b_addr_in];
        end
    end

endmodule

// ==== vlan_table_access_regs.sv ====
`timescale 1ns/1ps

// How it works
// - entry word 0 bit 31 is the entry valid flag, one means valid
// - bit 27 set forwards to entry port mask, clear leaves ports to others
// - entry word 0 bits 26:24 hold a read/write three-bit priority
// - entry word 0 bits 14:12 hold the spanning-tree instance index
// - entry word 0 bits 6:0 hold the seven-bit filter identifier
// - untag word bits 6:0 strip tags on egress, bit n is port n+1
// - forward word bits 6:0 permit ports, only applied under forward override
// - selector bits 11:0 pick the table entry the action works on
// - action 00 nop, 01 write, 10 read, 11 clear whole table
// - software sets bit 7 to start; hardware clears it when finished
module vlan_table_access_regs (
    input  wire logic                            clk_in,
    input  wire logic                            sys_rst_in,
    input  wire logic [15:0]                     reg_addr_in,
    input  wire logic                            reg_wr_in,
    input  wire logic                            reg_rd_in,
    input  wire logic [7:0]                      reg_wdata_in,
    output logic      [7:0]                      reg_rdata_out,
    output logic                                 reg_rvalid_out,
    output logic                                 busy_out,
    input  wire logic                            lookup_req_in,
    input  wire logic [vlan_regs_pkg::VID_W-1:0] lookup_vid_in,
    output logic                                 lookup_valid_out,
    output vlan_regs_pkg::lookup_result_t        lookup_out
);

    ////////////////////////////////////////////////////////////////////////////////
    // decoding helpers

    // byte lane 0 holds bits 7:0 and sits at the highest byte address
    function automatic logic lane_hit(
        input logic [15:0] addr,
        input logic [15:0] base,
        input int unsigned nbytes,
        input int unsigned lane
    );
        logic [15:0] lane_addr;
        lane_addr = base + 16'(nbytes - 1 - lane);
        return (lane < nbytes) && (addr == lane_addr);
    endfunction

    function automatic logic [7:0] pick_byte(
        input logic [31:0] word,
        input logic [15:0] base,
        input int unsigned nbytes,
        input logic [15:0] addr
    );
        logic [7:0] byte_v;
        byte_v = 8'h00;
        for (int unsigned lane = 0; lane < vlan_regs_pkg::WORD_BYTES; lane++) begin
            if (lane_hit(addr, base, nbytes, lane)) begin
                byte_v = byte_v | word[8*lane +: 8];
            end
        end
        return byte_v;
    endfunction

    function automatic logic reg_hit(
        input logic [15:0] addr,
        input logic [15:0] base,
        input int unsigned nbytes
    );
        logic hit_v;
        hit_v = 1'b0;
        for (int unsigned lane = 0; lane < vlan_regs_pkg::WORD_BYTES; lane++) begin
            hit_v = hit_v | lane_hit(addr, base, nbytes, lane);
        end
        return hit_v;
    endfunction

    // table entry to register word, reserved bits left zero
    function automatic logic [31:0] entry_word(
        input vlan_regs_pkg::vlan_entry_t e,
        input int unsigned                idx
    );
        logic [31:0] w;
        w = vlan_regs_pkg::WORD_RST;
        case (idx)
            0: begin
                w[vlan_regs_pkg::VALID_BIT] = e.valid;
                w[vlan_regs_pkg::OVRD_BIT] = e.forward_override;
                w[vlan_regs_pkg::PRIO_LSB +: vlan_regs_pkg::PRIO_W] = e.priority_level;
                w[vlan_regs_pkg::STI_LSB +: vlan_regs_pkg::STI_W] =
                    e.spanning_tree_instance;
                w[vlan_regs_pkg::FILT_LSB +: vlan_regs_pkg::FILT_W] = e.filter_identifier;
            end
            1: begin
                w[0 +: vlan_regs_pkg::PORT_W] = e.untag_mask;
            end
            2: begin
                w[0 +: vlan_regs_pkg::PORT_W] = e.forward_mask;
            end
            default: begin
                w = vlan_regs_pkg::WORD_RST;
            end
        endcase
        return w;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // state

    logic [31:0]                  regs_q [vlan_regs_pkg::NUM_WORDS];
    logic                         start_q;
    vlan_regs_pkg::action_t       action_q;
    vlan_regs_pkg::fsm_t          state_q;
    vlan_regs_pkg::fsm_t          state_d;
    logic [vlan_regs_pkg::VID_W-1:0] clr_cnt_q;
    logic [vlan_regs_pkg::VID_W-1:0] clr_cnt_d;
    logic [7:0]                   rdata_q;
    logic                         rvalid_q;
    logic                         lookup_pend_q;
    logic                         lookup_valid_q;
    vlan_regs_pkg::lookup_result_t lookup_q;

    ////////////////////////////////////////////////////////////////////////////////
    // sequencer wires

    logic                         done;
    logic                         load_entry;
    logic                         ram_en;
    logic                         ram_we;
    logic [vlan_regs_pkg::VID_W-1:0] ram_addr;
    vlan_regs_pkg::vlan_entry_t   ram_wdata;
    vlan_regs_pkg::vlan_entry_t   ram_rdata;
    vlan_regs_pkg::vlan_entry_t   lookup_rdata;
    vlan_regs_pkg::vlan_entry_t   staged_entry;
    wire logic [vlan_regs_pkg::VID_W-1:0] selected_vid;

    assign selected_vid = regs_q[3][vlan_regs_pkg::VID_W-1:0];

    // staged words packed into a table entry for write actions
    assign staged_entry.valid = regs_q[0][vlan_regs_pkg::VALID_BIT];
    assign staged_entry.forward_override = regs_q[0][vlan_regs_pkg::OVRD_BIT];
    assign staged_entry.priority_level =
        regs_q[0][vlan_regs_pkg::PRIO_LSB +: vlan_regs_pkg::PRIO_W];
    assign staged_entry.spanning_tree_instance =
        regs_q[0][vlan_regs_pkg::STI_LSB +: vlan_regs_pkg::STI_W];
    assign staged_entry.filter_identifier =
        regs_q[0][vlan_regs_pkg::FILT_LSB +: vlan_regs_pkg::FILT_W];
    assign staged_entry.untag_mask = regs_q[1][vlan_regs_pkg::PORT_W-1:0];
    assign staged_entry.forward_mask = regs_q[2][vlan_regs_pkg::PORT_W-1:0];

    ////////////////////////////////////////////////////////////////////////////////
    // register writes

    // staging registers are locked while an action runs so a write or read
    // action always works on a stable entry and index
    wire logic sw_write_ok;
    wire logic control_wr;

    assign sw_write_ok = reg_wr_in && !start_q;
    assign control_wr  = sw_write_ok && (reg_addr_in == vlan_regs_pkg::CONTROL_ADDR);

    genvar g;
    generate
        for (g = 0; g < vlan_regs_pkg::NUM_WORDS; g++) begin : gen_word
            always_ff @(posedge clk_in) begin
                if (sys_rst_in) begin
                    regs_q[g] <= vlan_regs_pkg::WORD_RST;
                end else if (load_entry && (g < vlan_regs_pkg::NUM_ENTRY_WORDS)) begin
                    regs_q[g] <= entry_word(ram_rdata, g);
                end else if (sw_write_ok) begin
                    for (int unsigned lane = 0; lane < vlan_regs_pkg::WORD_BYTES;
                         lane++) begin
                        if (lane_hit(reg_addr_in, vlan_regs_pkg::REG_BASE[g],
                                     vlan_regs_pkg::REG_BYTES[g], lane)) begin
                            regs_q[g][8*lane +: 8] <= reg_wdata_in &
                                vlan_regs_pkg::REG_MASK[g][8*lane +: 8];
                        end
                    end
                end
            end
        end
    endgenerate

    // hardware clears start only at completion; software cannot write while busy,
    // so there is never a set and a clear in the same cycle
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            start_q  <= 1'b0;
            action_q <= vlan_regs_pkg::ACT_NOP;
        end else if (control_wr) begin
            start_q  <= reg_wdata_in[vlan_regs_pkg::START_BIT];
            action_q <= vlan_regs_pkg::action_t'(reg_wdata_in[vlan_regs_pkg::ACTION_LSB +: 2]);
        end else if (done) begin
            start_q  <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // register reads

    wire logic [7:0] control_byte;
    wire logic [7:0] word_bytes [vlan_regs_pkg::NUM_WORDS];
    wire logic [7:0] read_byte;

    assign control_byte = {start_q, 5'b00000, action_q} & vlan_regs_pkg::CONTROL_MASK;

    generate
        for (g = 0; g < vlan_regs_pkg::NUM_WORDS; g++) begin : gen_rd
            assign word_bytes[g] = pick_byte(regs_q[g], vlan_regs_pkg::REG_BASE[g],
                                             vlan_regs_pkg::REG_BYTES[g], reg_addr_in);
        end
    endgenerate

    // unmapped addresses read as zero
    assign read_byte = word_bytes[0] | word_bytes[1] | word_bytes[2] | word_bytes[3] |
                       ((reg_addr_in == vlan_regs_pkg::CONTROL_ADDR) ?
                        control_byte : vlan_regs_pkg::BYTE_RST);

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            rdata_q  <= vlan_regs_pkg::BYTE_RST;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= reg_rd_in;
            if (reg_rd_in) begin
                rdata_q <= read_byte;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // action sequencer

    always_comb begin
        state_d    = state_q;
        clr_cnt_d  = clr_cnt_q;
        done       = 1'b0;
        load_entry = 1'b0;
        ram_en     = 1'b0;
        ram_we     = 1'b0;
        ram_addr   = selected_vid;
        ram_wdata  = staged_entry;
        case (state_q)
            vlan_regs_pkg::ST_IDLE: begin
                if (start_q) begin
                    case (action_q)
                        vlan_regs_pkg::ACT_WRITE: begin
                            ram_en = 1'b1;
                            ram_we = 1'b1;
                            done   = 1'b1;
                        end
                        vlan_regs_pkg::ACT_READ: begin
                            ram_en  = 1'b1;
                            state_d = vlan_regs_pkg::ST_READ;
                        end
                        vlan_regs_pkg::ACT_CLEAR: begin
                            clr_cnt_d = vlan_regs_pkg::INDEX_RST;
                            state_d   = vlan_regs_pkg::ST_CLEAR;
                        end
                        default: begin
                            done = 1'b1;
                        end
                    endcase
                end
            end
            vlan_regs_pkg::ST_READ: begin
                load_entry = 1'b1;
                done       = 1'b1;
                state_d    = vlan_regs_pkg::ST_IDLE;
            end
            vlan_regs_pkg::ST_CLEAR: begin
                ram_en    = 1'b1;
                ram_we    = 1'b1;
                ram_addr  = clr_cnt_q;
                ram_wdata = vlan_regs_pkg::ENTRY_RST;
                if (clr_cnt_q == vlan_regs_pkg::TABLE_LAST) begin
                    done    = 1'b1;
                    state_d = vlan_regs_pkg::ST_IDLE;
                end else begin
                    clr_cnt_d = clr_cnt_q + 12'h001;
                end
            end
            default: begin
                state_d = vlan_regs_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            state_q   <= vlan_regs_pkg::ST_IDLE;
            clr_cnt_q <= vlan_regs_pkg::INDEX_RST;
        end else begin
            state_q   <= state_d;
            clr_cnt_q <= clr_cnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // table storage

    vlan_table_ram u_table (
        .clk_in      (clk_in),
        .sys_rst_in  (sys_rst_in),
        .a_en_in     (ram_en),
        .a_we_in     (ram_we),
        .a_addr_in   (ram_addr),
        .a_wdata_in  (ram_wdata),
        .a_rdata_out (ram_rdata),
        .b_en_in     (lookup_req_in),
        .b_addr_in   (lookup_vid_in),
        .b_rdata_out (lookup_rdata)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // forwarding lookup port

    // without override every port stays permitted and other sources decide
    wire logic [vlan_regs_pkg::PORT_W-1:0] egress_ports;

    assign egress_ports = lookup_rdata.forward_override ?
                          lookup_rdata.forward_mask :
                          {vlan_regs_pkg::PORT_W{1'b1}};

    // a lookup during clear-all may see a partly cleared table
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            lookup_pend_q  <= 1'b0;
            lookup_valid_q <= 1'b0;
            lookup_q       <= '0;
        end else begin
            lookup_pend_q  <= lookup_req_in;
            lookup_valid_q <= lookup_pend_q;
            if (lookup_pend_q) begin
                lookup_q.entry            <= lookup_rdata;
                lookup_q.ports_from_entry <= lookup_rdata.forward_override;
                lookup_q.egress_ports     <= egress_ports;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs

    assign reg_rdata_out    = rdata_q;
    assign reg_rvalid_out   = rvalid_q;
    assign busy_out         = start_q;
    assign lookup_valid_out = lookup_valid_q;
    assign lookup_out       = lookup_q;

endmodule

// ==== vlan_table_access_regs_checker.sv ====
`timescale 1ns/1ps

module vlan_table_access_regs_checker (
    input wire logic                          clk_in,
    input wire logic                          sys_rst_in,
    input wire logic [15:0]                   reg_addr_in,
    input wire logic                          reg_wr_in,
    input wire logic                          reg_rd_in,
    input wire logic [7:0]                    reg_wdata_in,
    input wire logic [7:0]                    reg_rdata_out,
    input wire logic                          reg_rvalid_out,
    input wire logic                          busy_out,
    input wire logic                          lookup_req_in,
    input wire logic [11:0]                   lookup_vid_in,
    input wire logic                          lookup_valid_out,
    input wire vlan_regs_pkg::lookup_result_t lookup_out
);
    ////////////////////////////////////////////////////////////////////////////////
    logic [12:0] cnt_q;
    logic [12:0] cnt_d;
    wire         go_w;
    // clear-all is the longest action, so a longer busy run means a stuck start bit
    assign go_w  = reg_wr_in && !busy_out && reg_addr_in == vlan_regs_pkg::CONTROL_ADDR
                   && reg_wdata_in[7];
    assign cnt_d = busy_out ? cnt_q + 13'h0001 : 13'h0000;
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            cnt_q <= 13'h0000;
        end else begin
            cnt_q <= cnt_d;
        end
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    ////////////////////////////////////////////////////////////////////////////////
    property p_rvalid;
        reg_rd_in |=> reg_rvalid_out;
    endproperty
    a_rvalid: assert property (p_rvalid)
        else $error("read not answered");
    property p_start;
        go_w |=> busy_out;
    endproperty
    a_start: assert property (p_start)
        else $error("start did not raise busy");
    property p_write;
        go_w && reg_wdata_in[1:0] == 2'h1 |=> busy_out ##1 !busy_out;
    endproperty
    a_write: assert property (p_write)
        else $error("write action length wrong");
    property p_read;
        go_w && reg_wdata_in[1:0] == 2'h2 |=> busy_out [*2] ##1 !busy_out;
    endproperty
    a_read: assert property (p_read)
        else $error("read action length wrong");
    property p_nop;
        go_w && reg_wdata_in[1:0] == 2'h0 |=> busy_out ##1 !busy_out;
    endproperty
    a_nop: assert property (p_nop)
        else $error("nop action length wrong");
    property p_clear;
        go_w && reg_wdata_in[1:0] == 2'h3 |=> busy_out [*8];
    endproperty
    a_clear: assert property (p_clear)
        else $error("clear action ended early");
    property p_bound;
        cnt_q <= 13'h1001;
    endproperty
    a_bound: assert property (p_bound)
        else $error("busy never cleared");
    property p_lookup;
        lookup_req_in |-> ##2 lookup_valid_out;
    endproperty
    a_lookup: assert property (p_lookup)
        else $error("lookup not answered");
    property p_egress;
        lookup_valid_out |-> lookup_out.ports_from_entry == lookup_out.entry.forward_override
            && lookup_out.egress_ports == (lookup_out.ports_from_entry ?
               lookup_out.entry.forward_mask : 7'h7f);
    endproperty
    a_egress: assert property (p_egress)
        else $error("egress ports wrong");
    property p_reserved;
        reg_rvalid_out && $past(reg_addr_in) inside {16'h0401, 16'h040f} |-> reg_rdata_out == 8'h00;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved byte not zero");
endmodule

// ==== vlan_table_access_regs_tb.sv ====
`timescale 1ns/1ps

module vlan_table_access_regs_tb;
    logic                          clk_in = 1'b0;
    logic                          sys_rst_in = 1'b1;
    logic [15:0]                   reg_addr_in = 16'h0000;
    logic                          reg_wr_in = 1'b0;
    logic                          reg_rd_in = 1'b0;
    logic [7:0]                    reg_wdata_in = 8'h00;
    logic [7:0]                    reg_rdata_out;
    logic                          reg_rvalid_out;
    logic                          busy_out;
    logic                          lookup_req_in = 1'b0;
    logic [11:0]                   lookup_vid_in = 12'h000;
    logic                          lookup_valid_out;
    vlan_regs_pkg::lookup_result_t lookup_out;
    int                            failures = 0;
    int                            checks_done = 0;

    always #20 clk_in = ~clk_in;

    vlan_table_access_regs u_dut (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
        .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out), .busy_out(busy_out),
        .lookup_req_in(lookup_req_in), .lookup_vid_in(lookup_vid_in),
        .lookup_valid_out(lookup_valid_out), .lookup_out(lookup_out)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        if (failures == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // one idle cycle between strobes keeps each strobe a single assignment per step
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk_in);
        reg_addr_in = a;
        reg_wdata_in = d;
        reg_wr_in = 1'b1;
        @(negedge clk_in);
        reg_wr_in = 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(negedge clk_in);
        reg_addr_in = a;
        reg_rd_in = 1'b1;
        @(negedge clk_in);
        reg_rd_in = 1'b0;
        check({reg_rvalid_out, reg_rdata_out}, {1'b1, e});
    endtask

    // three entry words, big-endian bytes from 0x0400
    task automatic ent(input logic [95:0] e);
        for (int i = 0; i < 12; i++) wr(16'h0400 + 16'(i), e[95-8*i -: 8]);
    endtask

    task automatic rent(input logic [95:0] e);
        for (int i = 0; i < 12; i++) rd(16'h0400 + 16'(i), e[95-8*i -: 8]);
    endtask

    task automatic sel(input logic [11:0] v);
        wr(16'h040c, {4'h0, v[11:8]});
        wr(16'h040d, v[7:0]);
    endtask

    // c is the busy cycles already seen, n the expected total
    task automatic wait_idle(input int n, input int c);
        check(busy_out, 1'b1);
        while (busy_out === 1'b1 && c <= n) begin
            @(negedge clk_in);
            if (busy_out === 1'b1) c++;
        end
        check(c, n);
        if (c > n) summarize();
    endtask

    task automatic act(input logic [1:0] code, input int n);
        wr(16'h040e, {6'h20, code});
        wait_idle(n, 1);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(negedge clk_in);
        sys_rst_in = 1'b0;
        for (logic [15:0] a = 16'h0400; a < 16'h0411; a++) rd(a, 8'h00);
        act(2'h3, 4097);
        act(2'h0, 1);
        ent({3{32'hffff_ffff}});
        sel(12'hfff);
        rd(16'h040c, 8'h0f);
        rent({32'h8f00_707f, 32'h7f, 32'h7f});
        ent({32'h8b00_3015, 32'h55, 32'h2a});
        sel(12'h005);
        act(2'h1, 1);
        ent({32'h8400_4001, 32'h01, 32'h7e});
        sel(12'hfff);
        act(2'h1, 1);
        ent(96'h0);
        sel(12'h005);
        act(2'h2, 2);
        rent({32'h8b00_3015, 32'h55, 32'h2a});
        rd(16'h040e, 8'h02);
        sel(12'hfff);
        act(2'h2, 2);
        rent({32'h8400_4001, 32'h01, 32'h7e});
        @(negedge clk_in);
        lookup_req_in = 1'b1;
        lookup_vid_in = 12'h005;
        @(negedge clk_in);
        lookup_vid_in = 12'hfff;
        @(negedge clk_in);
        lookup_req_in = 1'b0;
        check({lookup_valid_out, lookup_out}, {9'h1db, 7'h15, 7'h55, 7'h2a, 8'haa});
        @(negedge clk_in);
        check({lookup_valid_out, lookup_out}, {9'h1a4, 7'h01, 7'h01, 7'h7e, 8'h7f});
        wr(16'h040e, 8'h01);
        check(busy_out, 1'b0);
        rd(16'h040e, 8'h01);
        // writes landing while busy must be dropped
        wr(16'h040e, 8'h83);
        wr(16'h040d, 8'h12);
        wait_idle(4097, 3);
        rd(16'h040d, 8'hff);
        sel(12'h005);
        act(2'h2, 2);
        rent(96'h0);
        @(negedge clk_in);
        sys_rst_in = 1'b1;
        repeat (2) @(negedge clk_in);
        sys_rst_in = 1'b0;
        rd(16'h040d, 8'h00);
        rd(16'h040e, 8'h00);
        summarize();
    end
endmodule

bind vlan_table_access_regs vlan_table_access_regs_checker u_chk (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out), .busy_out(busy_out),
    .lookup_req_in(lookup_req_in), .lookup_vid_in(lookup_vid_in),
    .lookup_valid_out(lookup_valid_out), .lookup_out(lookup_out)
);
